// ---- hw/afr_fault_report.sv ----
// Fault accumulation, prioritised readout, mute timing and pairing control of the amplifier.
`timescale 1ns/1ns
module afr_fault_report #(
	parameter int MEAS_CYCLES        = afr_pkg::MEAS_CYC,
	parameter int FAST_MUTE_CYCLES   = afr_pkg::FAST_MUTE_CYC,
	parameter int NORMAL_MUTE_CYCLES = afr_pkg::NORMAL_MUTE_CYC
) (
	input  wire logic                       clk,
	input  wire logic                       reset,
	input  wire logic [afr_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic [7:0]                 reg_wdata,
	input  wire logic                       reg_we,
	input  wire logic                       reg_re,
	output logic      [7:0]                 reg_rdata,
	input  wire logic                       link_clk,
	input  wire logic [3:0]                 det_short_gnd,
	input  wire logic [3:0]                 short_to_supply_fault,
	input  wire logic [3:0]                 det_short_load,
	input  wire logic [3:0]                 det_open_load,
	input  wire logic [3:0]                 det_offset,
	input  wire logic [2:0]                 thermal_warn,
	input  wire logic                       clip_comp,
	input  wire logic [1:0]                 power_demand_high,
	input  wire logic                       supply_low,
	output logic                            clip_detect_output,
	output logic      [1:0]                 pair_switch_close,
	output logic                            fast_mute_sel,
	output logic                            mute_busy,
	output logic                            diag_cycle_done
);
	import afr_pkg::*;

	// ------------------------------------------------------------
	// Input synchronisation
	// ------------------------------------------------------------
	localparam int SYNC_W = 28;

	logic [SYNC_W-1:0]  async_bus;
	logic [SYNC_W-1:0]  sync_bus;
	logic               link_s;
	logic [3:0]         gnd_s;
	logic [3:0]         vs_s;
	logic [3:0]         load_s;
	logic [3:0]         open_s;
	logic [3:0]         offs_s;
	logic [2:0]         tw_s;
	logic               clip_s;
	logic [1:0]         power_hi_s;
	logic               supply_low_s;

	// Every analogue comparator and the bus clock pin arrive unsynchronised
	assign async_bus = {supply_low, power_demand_high, clip_comp, thermal_warn, det_offset,
	                    det_open_load, det_short_load, short_to_supply_fault, det_short_gnd, link_clk};

	afr_sync #(
		.WIDTH (SYNC_W)
	) u_sync (
		.clk      (clk),
		.reset    (reset),
		.async_in (async_bus),
		.sync_out (sync_bus)
	);

	assign {supply_low_s, power_hi_s, clip_s, tw_s, offs_s, open_s, load_s, vs_s, gnd_s, link_s} = sync_bus;

	// ------------------------------------------------------------
	// Control registers and sample strobe
	// ------------------------------------------------------------
	logic [7:0] ib1_q;
	logic [7:0] ctl2_q;
	logic       link_prev_q;
	logic       sample_tick;
	logic       diag_en;
	logic       db1_read;

	assign diag_en  = ib1_q[IB1_DIAG_EN];
	assign db1_read = reg_re && (reg_addr == ADDR_DB1);

	// Instruction bytes; the unused bit of the second byte always reads zero
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ib1_q <= IB1_RST;
			ctl2_q <= CTL2_RST;
		end else if (reg_we) begin
			if (reg_addr == ADDR_IB1) begin
				ib1_q <= reg_wdata;
			end
			if (reg_addr == ADDR_CTL2) begin
				ctl2_q <= reg_wdata & ~(8'h01 << CTL2_ZERO_BIT);
			end
		end
	end

	// Bus clock rising edges pace the fault samples
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			link_prev_q <= 1'b0;
		end else begin
			link_prev_q <= link_s;
		end
	end

	assign sample_tick = link_s & ~link_prev_q;

	// ------------------------------------------------------------
	// Diagnostic cycle sequencing
	// ------------------------------------------------------------
	afr_diag_state_e state_q;
	logic [31:0]     meas_cnt_q;
	logic            meas_end;
	logic            cycle_start;
	logic            cycle_turnon_q;
	logic            turnon_pending_q;
	logic            turnon_set;
	logic            turnon_clr;

	assign meas_end    = (state_q == DS_MEASURE) && (meas_cnt_q == 32'(MEAS_CYCLES - 1));
	assign cycle_start = (state_q == DS_IDLE) && diag_en && !db1_read;
	assign turnon_set  = reg_we && (reg_addr == ADDR_CTL2) && reg_wdata[CTL2_STBY_OFF] && !ctl2_q[CTL2_STBY_OFF];
	assign turnon_clr  = meas_end && cycle_turnon_q;

	// A first-byte read aborts or closes any cycle and lets a fresh one start; disabling stops all cycles
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_q <= DS_IDLE;
		end else if (db1_read || !diag_en) begin
			state_q <= DS_IDLE;
		end else begin
			unique case (state_q)
				DS_IDLE: begin
					state_q <= DS_MEASURE;
				end
				DS_MEASURE: begin
					if (meas_end) begin
						state_q <= DS_DONE;
					end
				end
				DS_DONE: begin
					state_q <= DS_DONE;
				end
			endcase
		end
	end

	// Window length counter
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			meas_cnt_q <= 32'h0000_0000;
		end else if (state_q != DS_MEASURE || db1_read) begin
			meas_cnt_q <= 32'h0000_0000;
		end else begin
			meas_cnt_q <= meas_cnt_q + 32'h0000_0001;
		end
	end

	// Leaving standby asks for one turn-on cycle; a new request beats the clear
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			turnon_pending_q <= 1'b0;
			cycle_turnon_q   <= 1'b0;
		end else begin
			turnon_pending_q <= turnon_set | (turnon_pending_q & ~turnon_clr);
			if (cycle_start) begin
				cycle_turnon_q <= turnon_pending_q | turnon_set;
			end
		end
	end

	// ------------------------------------------------------------
	// Fault accumulators
	// ------------------------------------------------------------
	logic [3:0] acc_gnd_q;
	logic [3:0] acc_vs_q;
	logic [3:0] acc_load_q;
	logic [3:0] acc_open_q;
	logic [3:0] acc_offs_q;
	logic       seen_q;

	// Start all ones and AND in each sample, so one clean sample kills a flag
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			acc_gnd_q  <= 4'h0;
			acc_vs_q   <= 4'h0;
			acc_load_q <= 4'h0;
			acc_open_q <= 4'h0;
			acc_offs_q <= 4'h0;
			seen_q     <= 1'b0;
		end else if (cycle_start) begin
			acc_gnd_q  <= 4'hF;
			acc_vs_q   <= 4'hF;
			acc_load_q <= 4'hF;
			acc_open_q <= 4'hF;
			acc_offs_q <= 4'hF;
			seen_q     <= 1'b0;
		end else if (state_q == DS_MEASURE && sample_tick) begin
			acc_gnd_q  <= acc_gnd_q & gnd_s;
			acc_vs_q   <= acc_vs_q & vs_s;
			acc_load_q <= acc_load_q & load_s;
			acc_open_q <= acc_open_q & open_s;
			acc_offs_q <= acc_offs_q & offs_s;
			seen_q     <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Priority resolution and result latch
	// ------------------------------------------------------------
	logic [3:0] gnd_v;
	logic [3:0] vs_v;
	logic [3:0] load_v;
	logic [3:0] open_v;
	logic [3:0] offs_v;
	logic [5:0] res_v    [NUM_CH];
	logic [5:0] result_q [NUM_CH];

	// A short hides any load fault on that channel until it is cleared and read again
	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			gnd_v[i]  = acc_gnd_q[i] & seen_q;
			vs_v[i]   = acc_vs_q[i] & seen_q;
			load_v[i] = acc_load_q[i] & seen_q & ~(gnd_v[i] | vs_v[i]);
			open_v[i] = acc_open_q[i] & seen_q & cycle_turnon_q & ~(gnd_v[i] | vs_v[i] | load_v[i]);
			offs_v[i] = acc_offs_q[i] & seen_q & ~cycle_turnon_q & ib1_q[IB1_OFFSET_EN];
			res_v[i]  = {1'b0, ~cycle_turnon_q, load_v[i], open_v[i] | offs_v[i], vs_v[i], gnd_v[i]};
		end
	end

	// Results change only when a window completes, never on a read
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			for (int i = 0; i < NUM_CH; i++) begin
				result_q[i] <= 6'h00;
			end
		end else if (meas_end) begin
			for (int i = 0; i < NUM_CH; i++) begin
				result_q[i] <= res_v[i];
			end
		end
	end

	// ------------------------------------------------------------
	// Readout buffer and register reads
	// ------------------------------------------------------------
	logic [7:0] db_v   [NUM_CH];
	logic [7:0] buf_q  [NUM_CH];
	logic [7:0] rdata_q;

	assign db_v[0] = {tw_s[0], state_q == DS_DONE, 2'b00, result_q[0][3:0]} | {4'h0, result_q[0][3:0]}
	               | {3'b000, result_q[0][DB_PERM], 4'h0};
	assign db_v[1] = {ib1_q[IB1_OFFSET_EN], 1'b0, result_q[1]};
	assign db_v[2] = {ctl2_q[CTL2_STBY_OFF], ib1_q[IB1_DIAG_EN], result_q[2]};
	assign db_v[3] = {tw_s[1], tw_s[2], result_q[3]};

	// The first byte read freezes all four, so one sequence is coherent
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			for (int i = 0; i < NUM_CH; i++) begin
				buf_q[i] <= 8'h00;
			end
		end else if (db1_read) begin
			for (int i = 0; i < NUM_CH; i++) begin
				buf_q[i] <= db_v[i];
			end
		end
	end

	// Read data stand only in the cycle after the strobe; unmapped reads give zero
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rdata_q <= 8'h00;
		end else if (reg_re) begin
			case (reg_addr)
				ADDR_IB1: rdata_q <= ib1_q;
				ADDR_CTL2: rdata_q <= ctl2_q;
				ADDR_DB1: rdata_q <= db_v[0];
				ADDR_DB2: rdata_q <= buf_q[1];
				ADDR_DB3: rdata_q <= buf_q[2];
				ADDR_DB4: rdata_q <= buf_q[3];
				default:  rdata_q <= 8'h00;
			endcase
		end else begin
			rdata_q <= 8'h00;
		end
	end

	assign reg_rdata       = rdata_q;
	assign diag_cycle_done = (state_q == DS_DONE);

	// ------------------------------------------------------------
	// Mute timing, clip output and pairing switches
	// ------------------------------------------------------------
	logic [31:0] mute_cnt_q;
	logic        mute_enter;
	logic        clip_q;
	logic [1:0]  pair_q;

	assign mute_enter = reg_we && (reg_addr == ADDR_IB1)
	                 && ((ib1_q[IB1_UNMUTE_F] && !reg_wdata[IB1_UNMUTE_F])
	                  || (ib1_q[IB1_UNMUTE_R] && !reg_wdata[IB1_UNMUTE_R]));

	// Fast bit is left as written; host must drop it after the ramp
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			mute_cnt_q <= 32'h0000_0000;
		end else if (mute_enter) begin
			mute_cnt_q <= ctl2_q[CTL2_FAST_MUTE] ? 32'(FAST_MUTE_CYCLES) : 32'(NORMAL_MUTE_CYCLES);
		end else if (mute_cnt_q != 32'h0000_0000) begin
			mute_cnt_q <= mute_cnt_q - 32'h0000_0001;
		end
	end

	assign mute_busy     = (mute_cnt_q != 32'h0000_0000);
	assign fast_mute_sel = ctl2_q[CTL2_FAST_MUTE];

	// Clip comparator passes straight on, so in shutdown it toggles or rests low with the signal
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			clip_q <= 1'b0;
		end else begin
			clip_q <= clip_s;
		end
	end

	assign clip_detect_output = clip_q;

	// Switch closes only at low demand with healthy supply; no reprogramming after a dip
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pair_q <= 2'b00;
		end else begin
			pair_q[0] <= ctl2_q[CTL2_HE_LEFT] && !power_hi_s[0] && !supply_low_s;
			pair_q[1] <= ctl2_q[CTL2_HE_RIGHT] && !power_hi_s[1] && !supply_low_s;
		end
	end

	assign pair_switch_close = pair_q;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	a_pair_low_supply: assert property (@(posedge clk) disable iff (reset)
		supply_low_s |=> pair_switch_close == 2'b00)
		else $error("pairing switch closed at low supply");

	a_pair_high_power: assert property (@(posedge clk) disable iff (reset)
		power_hi_s[0] |=> !pair_switch_close[0])
		else $error("pairing switch closed at high power");

	a_pair_close_low: assert property (@(posedge clk) disable iff (reset)
		(ctl2_q[CTL2_HE_LEFT] && !power_hi_s[0] && !supply_low_s) |=> pair_switch_close[0])
		else $error("pairing switch failed to close");

	a_read_rearm: assert property (@(posedge clk) disable iff (reset)
		db1_read |=> state_q == DS_IDLE ##1 (state_q == DS_MEASURE || !diag_en || $past(db1_read)))
		else $error("read did not re-arm the cycle");

	a_read_prev_data: assert property (@(posedge clk) disable iff (reset)
		db1_read |=> reg_rdata[3:0] == $past(result_q[0][3:0]))
		else $error("read data not from completed cycle");

	a_done_flag: assert property (@(posedge clk) disable iff (reset)
		db1_read |=> reg_rdata[DB_NEXT] == $past(state_q == DS_DONE))
		else $error("cycle terminated flag wrong");

	a_warn_report: assert property (@(posedge clk) disable iff (reset)
		(reg_re && reg_addr == ADDR_DB4) |=> reg_rdata[7:6] == $past({buf_q[3][7], buf_q[3][6]}))
		else $error("thermal warning bits wrong");

	a_no_perm_open: assert property (@(posedge clk) disable iff (reset)
		!cycle_turnon_q |-> open_v == 4'h0)
		else $error("open load in permanent cycle");

	a_short_priority: assert property (@(posedge clk) disable iff (reset)
		((gnd_v | vs_v) & (load_v | open_v)) == 4'h0)
		else $error("load fault shown beside a short");

	a_sample_persist: assert property (@(posedge clk) disable iff (reset)
		(state_q == DS_MEASURE && sample_tick && !gnd_s[0] && !db1_read) |=> !acc_gnd_q[0])
		else $error("fault kept after a clean sample");

	a_fast_mute_len: assert property (@(posedge clk) disable iff (reset)
		($rose(mute_busy) && fast_mute_sel) |-> mute_cnt_q == 32'(FAST_MUTE_CYCLES))
		else $error("fast mute length wrong");

	c_cycle_done: cover property (@(posedge clk) disable iff (reset) meas_end);
	c_fault_read: cover property (@(posedge clk) disable iff (reset) db1_read && result_q[0] != 6'h00);
	c_pair_closed: cover property (@(posedge clk) disable iff (reset) pair_switch_close == 2'b11);
	c_fast_mute: cover property (@(posedge clk) disable iff (reset) mute_busy && fast_mute_sel);

endmodule

// ---- hw/afr_pkg.sv ----
// Shared constants, register map and state type of the amplifier fault-report logic.
// Contract
// - At least one of several faults reported first.
// - Other faults follow later reads, diagnostics enabled.
// - Shorts to ground or supply outrank load faults.
// - Short with speaker missing counts double.
// - Permanent cycle never reports open load.
// - Report fault only if stable whole period.
// - Every diagnostic read re-arms all cycles.
// - Read returns previous completed cycle results.
// - Three thermal warnings readable by host.
// - Clip output follows signal after shutdown.
// - Fast-mute bit shortens mute below 1.5 ms; the code ramps for exactly 1.5 ms (FAST_MUTE_TIME_US = 1500).
// - Low power closes channel pairing switches.
// - High power demand opens pairing switch.
// - Low supply disables pairing, recovers automatically.
// - Warning bits in first and fourth bytes.
// - Cycle-terminated flag in first byte bit 6.
package afr_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam int         ADDR_W     = 3;
	localparam logic [2:0] ADDR_IB1   = 3'h0;
	localparam logic [2:0] ADDR_CTL2  = 3'h1;
	localparam logic [2:0] ADDR_DB1   = 3'h2;
	localparam logic [2:0] ADDR_DB2   = 3'h3;
	localparam logic [2:0] ADDR_DB3   = 3'h4;
	localparam logic [2:0] ADDR_DB4   = 3'h5;
	localparam logic [7:0] IB1_RST    = 8'h00;
	localparam logic [7:0] CTL2_RST   = 8'h00;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int IB1_DIAG_EN     = 6;
	localparam int IB1_OFFSET_EN   = 5;
	localparam int IB1_UNMUTE_F    = 2;
	localparam int IB1_UNMUTE_R    = 1;
	localparam int CTL2_ZERO_BIT   = 6;
	localparam int CTL2_FAST_MUTE  = 5;
	localparam int CTL2_STBY_OFF   = 4;
	localparam int CTL2_HE_RIGHT   = 1;
	localparam int CTL2_HE_LEFT    = 0;
	localparam int DB_TOP          = 7;
	localparam int DB_NEXT         = 6;
	localparam int DB_PERM         = 4;
	localparam int DB_SHORT_LOAD   = 3;
	localparam int DB_OPEN_OFFS    = 2;
	localparam int DB_SHORT_VS     = 1;
	localparam int DB_SHORT_GND    = 0;
	localparam int NUM_CH          = 4;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_FREQ_HZ         = 20_000_000;
	localparam int MEAS_TIME_MS        = 100;
	localparam int MEAS_CYC            = MEAS_TIME_MS * (CLK_FREQ_HZ / 1000);
	localparam int FAST_MUTE_TIME_US   = 1500;
	localparam int FAST_MUTE_CYC       = (FAST_MUTE_TIME_US * (CLK_FREQ_HZ / 1000)) / 1000;
	localparam int NORMAL_MUTE_TIME_MS = 20;
	localparam int NORMAL_MUTE_CYC     = NORMAL_MUTE_TIME_MS * (CLK_FREQ_HZ / 1000);

	// Diagnostic cycle sequencing
	typedef enum logic [1:0] {DS_IDLE, DS_MEASURE, DS_DONE} afr_diag_state_e;

endpackage

// ---- hw/afr_sync.sv ----
// Two-flop synchroniser for a bundle of asynchronous levels.
`timescale 1ns/1ns
module afr_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q;

	// First stage feeds only the second stage
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			meta_q   <= '0;
			sync_out <= '0;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule

// ---- testbench/afr_fault_report_tb.sv ----
// Self-checking bench of the amplifier fault-report logic.
`timescale 1ns/1ns
module afr_fault_report_tb;
	import afr_pkg::*;
	typedef struct {logic [7:0] exp; logic [7:0] msk; string nm;} afr_note_s;
	logic       clk, reset, reg_we, reg_re, clip_comp, supply_low, run_link, re_seen;
	logic [2:0] reg_addr, thermal_warn;
	logic [7:0] reg_wdata, reg_rdata;
	logic [3:0] d_gnd, d_vs, d_load, d_open;
	logic [1:0] pdh, pair;
	logic       link_clk, clip_out, fm_sel, mute_busy, done;
	logic [15:0] rnd;
	int         error_cnt, checked, cyc;
	afr_note_s  notes[$];
	afr_note_s  cur;

	afr_fault_report #(.MEAS_CYCLES(64), .FAST_MUTE_CYCLES(20), .NORMAL_MUTE_CYCLES(40)) i_dut (
		.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
		.reg_re(reg_re), .reg_rdata(reg_rdata), .link_clk(link_clk), .det_short_gnd(d_gnd),
		.short_to_supply_fault(d_vs), .det_short_load(d_load), .det_open_load(d_open),
		.det_offset(4'h0), .thermal_warn(thermal_warn), .clip_comp(clip_comp),
		.power_demand_high(pdh), .supply_low(supply_low), .clip_detect_output(clip_out),
		.pair_switch_close(pair), .fast_mute_sel(fm_sel), .mute_busy(mute_busy), .diag_cycle_done(done)
	);

	afr_host_link i_host (.run(run_link), .link_clk(link_clk));

	// ------------------------------------------------------------
	// Clock, timeout and read-data monitor
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// Ceiling far above the several hundred cycles the sequence needs
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			report_and_stop();
		end
	end

	// Read data stands only in the cycle after the strobe, so pair each note with that cycle
	always @(posedge clk) begin
		if (re_seen === 1'b1 && notes.size() > 0) begin
			cur = notes.pop_front();
			check(cur.nm, {24'h0, reg_rdata & cur.msk}, {24'h0, cur.exp});
		end
		re_seen <= reg_re;
	end

	function automatic logic [15:0] lfsr(logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask

	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// Register bus tasks
	// ------------------------------------------------------------
	task automatic wr(logic [2:0] a, logic [7:0] d);
		@(posedge clk);
		reg_we <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_we <= 1'b0;
	endtask

	task automatic rd(logic [2:0] a, logic [7:0] e, logic [7:0] m, string nm);
		@(posedge clk);
		notes.push_back('{e, m, nm});
		reg_re <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_re <= 1'b0;
	endtask

	// DB1 first: it takes the snapshot the other three return
	task automatic rd4(logic [31:0] e, string nm);
		for (int i = 0; i < 4; i++) begin
			rd(ADDR_DB1 + 3'(i), e[31-8*i -: 8], 8'hFF, nm);
		end
	endtask

	task automatic settle();
		repeat (5) @(posedge clk);
		@(negedge clk);
	endtask

	task automatic wait_done();
		int i;
		for (i = 0; i < 300 && done !== 1'b1; i++) begin
			@(negedge clk);
		end
		check("diag_cycle_done", {31'h0, done}, 32'h1);
	endtask

	// Sets an unmute bit, clears it again and counts the ramp length
	task automatic mute_len(int exp_n);
		int n;
		n = 0;
		wr(ADDR_IB1, 8'h46);
		wr(ADDR_IB1, 8'h42);
		repeat (120) begin
			@(negedge clk);
			if (mute_busy === 1'b1) n++;
		end
		check("mute_busy cycles", n, exp_n);
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		reset = 1'b1;
		{reg_we, reg_re, clip_comp, supply_low, run_link, re_seen} = 6'h00;
		{reg_addr, reg_wdata, thermal_warn, pdh} = 16'h0000;
		{d_gnd, d_vs, d_load, d_open} = 16'h0000;
		rnd = 16'h2B35;
		error_cnt = 0;
		checked = 0;
		cyc = 0;
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		@(negedge clk);
		check("outputs after reset", {27'h0, pair, mute_busy, done, clip_out}, 32'h0);
		// Bit 6 of the second instruction byte reads back zero; unmapped places stay quiet
		wr(ADDR_CTL2, 8'h53);
		wr(3'h3, 8'hFF);
		rd(ADDR_CTL2, 8'h13, 8'hFF, "second_instruction_byte");
		rd(3'h6, 8'h00, 8'hFF, "unmapped 6");
		rd(3'h7, 8'h00, 8'hFF, "unmapped 7");
		// Random pairing enables, power demand, supply and clip levels
		repeat (12) begin
			rnd = lfsr(rnd);
			wr(ADDR_CTL2, {6'h04, rnd[1:0]});
			pdh <= rnd[3:2];
			supply_low <= rnd[4];
			clip_comp <= rnd[5];
			settle();
			check("pair_switch_close", pair, rnd[1:0] & ~rnd[3:2] & {2{~rnd[4]}});
			check("clip_detect_output", clip_out, rnd[5]);
		end
		// Low supply opens both switches; recovery needs no rewrite
		wr(ADDR_CTL2, 8'h13);
		pdh <= 2'b00;
		supply_low <= 1'b1;
		settle();
		check("pair at low supply", pair, 2'b00);
		supply_low <= 1'b0;
		settle();
		check("pair after recovery", pair, 2'b11);
		// Turn-on cycle with double faults on channels 0 to 2 and an open load alone on channel 3
		run_link <= 1'b1;
		d_gnd <= 4'h5;
		d_vs <= 4'h4;
		d_load <= 4'h2;
		d_open <= 4'hB;
		thermal_warn <= 3'b110;
		settle();
		wr(ADDR_IB1, 8'h40);
		wait_done();
		rd4(32'h4108C3C4, "turn-on bytes");
		// Permanent cycle completes, faults are removed, the next read still shows them
		thermal_warn <= 3'b001;
		wait_done();
		{d_gnd, d_vs, d_load, d_open} <= 16'h0000;
		repeat (10) @(posedge clk);
		rd4(32'hD118D310, "held bytes");
		// A fault shorter than the window never reaches the bytes; second read shows the change
		d_gnd <= 4'h1;
		thermal_warn <= 3'b000;
		repeat (30) @(posedge clk);
		d_gnd <= 4'h0;
		wait_done();
		rd4(32'h5010D010, "clean bytes");
		rd(ADDR_DB1, 8'h00, 8'h40, "cycle flag");
		run_link <= 1'b0;
		// Normal then fast mute ramps
		mute_len(40);
		wr(ADDR_CTL2, 8'h33);
		@(negedge clk);
		check("fast_mute_sel", fm_sel, 1'b1);
		mute_len(20);
		wr(ADDR_CTL2, 8'h13);
		@(negedge clk);
		check("fast_mute_sel cleared", fm_sel, 1'b0);
		repeat (4) @(posedge clk);
		report_and_stop();
	end
endmodule

// ---- testbench/afr_host_link.sv ----
// Host-side bus clock source for the fault-report bench.
`timescale 1ns/1ns
module afr_host_link #(
	parameter int HALF_NS = 200
) (
	input  wire logic run,
	output logic      link_clk
);
	// ------------------------------------------------------------
	// Bus clock
	// ------------------------------------------------------------
	// Toggles only inside frames; the pulled-up line rests high between them
	initial begin
		link_clk = 1'b1;
		#7;
		forever begin
			#HALF_NS;
			link_clk = run ? ~link_clk : 1'b1;
		end
	end
endmodule
